// ==== dacswp_pkg.sv ====
package dacswp_pkg;
    localparam int FRAME_BITS = 24;
    localparam int CODE_BITS = 16;
    localparam int CNT_W = 5;
    localparam logic [CNT_W-1:0] CNT_RST = 5'h00;
    localparam logic [CODE_BITS-1:0] CODE_RST = 16'h0000;
    localparam logic [FRAME_BITS-1:0] WORD_RST = 24'h000000;
    localparam int SYNC_STAGES = 3;
    typedef enum logic [1:0] {DACSWP_IDLE, DACSWP_SHIFT, DACSWP_DONE} dacswp_state_t;
endpackage : dacswp_pkg

// ==== dacswp_sync_if.sv ====
`timescale 1ns/100ps
`default_nettype none
interface dacswp_sync_if;
    logic sclk_fall;
    logic sel_low;
    logic sel_rise;
    logic din;
    modport src (output sclk_fall, output sel_low, output sel_rise, output din);
    modport dst (input sclk_fall, input sel_low, input sel_rise, input din);
endinterface : dacswp_sync_if
`default_nettype wire

// ==== dacswp_pin_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
module dacswp_pin_sync
    import dacswp_pkg::*;
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // pins
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic din_i,
    // conditioned events
    dacswp_sync_if.src ev
);
    logic [SYNC_STAGES-1:0] sclk_r, sel_r, din_r;
    logic sclk_q_r, sel_q_r, din_q_r;
    logic sclk_q_nxt, sel_q_nxt, din_q_nxt;

    // stage two and three agreeing filters single-sample glitches
    always_comb begin
        sclk_q_nxt = (sclk_r[1] == sclk_r[2]) ? sclk_r[2] : sclk_q_r;
        sel_q_nxt = (sel_r[1] == sel_r[2]) ? sel_r[2] : sel_q_r;
        din_q_nxt = (din_r[1] == din_r[2]) ? din_r[2] : din_q_r;
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            sclk_r <= '0;
            sel_r <= '1;
            din_r <= '0;
            sclk_q_r <= 1'b0;
            sel_q_r <= 1'b1;
            din_q_r <= 1'b0;
        end else begin
            sclk_r <= {sclk_r[SYNC_STAGES-2:0], sclk_i};
            sel_r <= {sel_r[SYNC_STAGES-2:0], sel_n_i};
            din_r <= {din_r[SYNC_STAGES-2:0], din_i};
            sclk_q_r <= sclk_q_nxt;
            sel_q_r <= sel_q_nxt;
            din_q_r <= din_q_nxt;
        end
    end

    // din is delayed like sclk so the bit is sampled as it stood at the fall
    assign ev.sclk_fall = sclk_q_r & ~sclk_q_nxt;
    assign ev.sel_low = ~sel_q_r;
    assign ev.sel_rise = ~sel_q_r & sel_q_nxt;
    assign ev.din = din_q_r;
endmodule : dacswp_pin_sync
`default_nettype wire

// ==== dacswp_port.sv ====
`timescale 1ns/100ps
`default_nettype none
// Function
// - frame select low frames a write
// - frame select low enables shift register
// - data sampled on serial clock falling edge
// - shift register is 24 bits wide
// - 24th falling edge updates dac output
// - early frame select rise aborts, discards
// - code is straight binary 0 to 65535
module dacswp_port
    import dacswp_pkg::*;
#(
    parameter int WORD_W = FRAME_BITS
) (
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // serial pins
    input wire logic sclk_i,
    input wire logic sel_n_i,
    input wire logic din_i,
    // converter side
    output logic [CODE_BITS-1:0] analog_output_code_o,
    output logic [WORD_W-1:0] frame_word_o,
    output logic update_o,
    output logic busy_o
);
    // counter, code slice and last-bit decode assume one frame layout
    if (WORD_W != FRAME_BITS) begin : g_bad_word_w
        $error("dacswp_port: WORD_W must equal FRAME_BITS");
    end
    if (WORD_W < CODE_BITS) begin : g_bad_code_w
        $error("dacswp_port: WORD_W is narrower than the code");
    end
    if ((2 ** CNT_W) <= WORD_W) begin : g_bad_cnt_w
        $error("dacswp_port: CNT_W cannot count a whole frame");
    end
    if (SYNC_STAGES < 3) begin : g_bad_sync
        $error("dacswp_port: the pin filter needs three stages");
    end

    dacswp_sync_if ev();

    dacswp_pin_sync u_sync (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .sclk_i(sclk_i),
        .sel_n_i(sel_n_i),
        .din_i(din_i),
        .ev(ev)
    );

    // local names for the conditioned pin events
    logic fall_w;
    logic sel_low_w;
    logic sel_rise_w;
    logic din_w;

    assign fall_w = ev.sclk_fall;
    assign sel_low_w = ev.sel_low;
    assign sel_rise_w = ev.sel_rise;
    assign din_w = ev.din;

    // a frame is being shifted in
    function automatic logic shifting(
        input dacswp_state_t st
    );
        return st == DACSWP_SHIFT;
    endfunction : shifting

    // bits are taken while armed or shifting, never once the frame is full
    function automatic logic can_take(
        input dacswp_state_t st,
        input logic sel_low
    );
        return sel_low && ((st == DACSWP_IDLE) || (st == DACSWP_SHIFT));
    endfunction : can_take

    // the fall that brings the count to a full frame
    function automatic logic is_last(
        input dacswp_state_t st,
        input logic [CNT_W-1:0] cnt
    );
        return shifting(st) && (cnt == CNT_W'(WORD_W - 1));
    endfunction : is_last

    dacswp_state_t state_r;
    dacswp_state_t state_nxt;
    logic [WORD_W-1:0] shift_r;
    logic [WORD_W-1:0] shift_nxt;
    logic [WORD_W-1:0] shift_in_w;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [WORD_W-1:0] word_r;
    logic [WORD_W-1:0] word_nxt;
    logic [CODE_BITS-1:0] code_r;
    logic [CODE_BITS-1:0] code_nxt;
    logic upd_r;
    logic upd_nxt;
    logic take_w;
    logic last_w;

    // din carries the same delay as the edge that samples it
    assign shift_in_w[0] = din_w;
    for (genvar gi = 1; gi < WORD_W; gi++) begin : g_chain
        assign shift_in_w[gi] = shift_r[gi-1];
    end

    // falls while frame select is high or after the last bit are dropped
    assign take_w = can_take(state_r, sel_low_w) && fall_w;
    assign last_w = take_w && is_last(state_r, cnt_r);

    // frame state
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DACSWP_IDLE: begin
                if (can_take(state_r, sel_low_w)) begin
                    state_nxt = DACSWP_SHIFT;
                end
            end
            DACSWP_SHIFT: begin
                if (!sel_low_w) begin
                    state_nxt = DACSWP_IDLE;
                end else if (take_w && is_last(state_r, cnt_r)) begin
                    state_nxt = DACSWP_DONE;
                end
            end
            DACSWP_DONE: begin
                // only a rise then a fresh fall of frame select rearms
                if (sel_rise_w || !sel_low_w) begin
                    state_nxt = DACSWP_IDLE;
                end
            end
            default: begin
                state_nxt = DACSWP_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r <= DACSWP_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // shift register and bit count
    always_comb begin
        shift_nxt = shift_r;
        cnt_nxt = cnt_r;
        case (state_r)
            DACSWP_IDLE: begin
                cnt_nxt = CNT_RST;
                if (take_w) begin
                    shift_nxt = shift_in_w;
                    cnt_nxt = 5'h01;
                end
            end
            DACSWP_SHIFT: begin
                if (take_w) begin
                    shift_nxt = shift_in_w;
                    cnt_nxt = cnt_r + 5'h01;
                end
            end
            DACSWP_DONE: begin
                // the count stays full; can_take drops every fall in this state
                cnt_nxt = cnt_r;
            end
            default: begin
                cnt_nxt = CNT_RST;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            shift_r <= WORD_RST;
            cnt_r <= CNT_RST;
        end else begin
            shift_r <= shift_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // converter word, code and update strobe
    always_comb begin
        word_nxt = word_r;
        code_nxt = code_r;
        upd_nxt = 1'b0;
        case (state_r)
            DACSWP_SHIFT: begin
                // an aborted frame never gets here, so the old code stands
                if (last_w) begin
                    word_nxt = shift_in_w;
                    // low bits carry the straight binary code
                    code_nxt = shift_in_w[CODE_BITS-1:0];
                    upd_nxt = 1'b1;
                end
            end
            default: begin
                upd_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            word_r <= WORD_RST;
            code_r <= CODE_RST;
            upd_r <= 1'b0;
        end else begin
            word_r <= word_nxt;
            code_r <= code_nxt;
            upd_r <= upd_nxt;
        end
    end

    assign analog_output_code_o = code_r;
    assign frame_word_o = word_r;
    assign update_o = upd_r;
    assign busy_o = shifting(state_r);
endmodule : dacswp_port
`default_nettype wire

// ==== dacswp_port_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module dacswp_port_sva import dacswp_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic sel_n_i,
    input wire logic [CODE_BITS-1:0] analog_output_code_o,
    input wire logic [FRAME_BITS-1:0] frame_word_o,
    input wire logic update_o,
    input wire logic busy_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    sequence s_arm; $fell(sel_n_i) ##1 !sel_n_i [*7]; endsequence
    sequence s_upd_low; update_o ##1 !sel_n_i [*6]; endsequence
    a_upd_pulse: assert property (update_o |=> !update_o) else $error("long update");
    a_upd_busy: assert property (update_o |-> $past(busy_o)) else $error("idle update");
    a_arm_busy: assert property (s_arm |-> busy_o) else $error("not armed");
    a_idle_quiet: assert property (sel_n_i [*8] |-> !busy_o) else $error("busy idle");
    a_word_hold: assert property ($changed(frame_word_o) |-> update_o) else $error("word");
    a_code_hold: assert property ($changed(analog_output_code_o) |-> update_o) else $error("cd");
    a_code_low: assert property (update_o |-> analog_output_code_o == frame_word_o[15:0])
        else $error("code field");
    a_extra_quiet: assert property (s_upd_low |-> !busy_o) else $error("rearmed");
endmodule : dacswp_port_sva
bind dacswp_port dacswp_port_sva u_sva (.clk_sys_i, .rst_i, .sel_n_i, .analog_output_code_o,
    .frame_word_o, .update_o, .busy_o);
`default_nettype wire

// ==== dacswp_host.sv ====
`timescale 1ns/100ps
`default_nettype none
module dacswp_host (
    output logic sclk_o = 1'b1,
    output logic sel_n_o = 1'b1,
    output logic din_o = 1'b0
);
    // bits past 24 are inverted so a shifting slip shows up
    task automatic frame(input logic [23:0] w, input int n);
        sel_n_o = 1'b0;
        #20;
        for (int i = 0; i < n; i++) begin
            din_o = w[23 - (i % 24)] ^ (i >= 24);
            #32 sclk_o = 1'b0;
            #32 sclk_o = 1'b1;
        end
        #20 sel_n_o = 1'b1;
        din_o = ~din_o;
        #100;
    endtask : frame
endmodule : dacswp_host
`default_nettype wire

// ==== dac_serial_write_port_test.sv ====
`timescale 1ns/100ps
`default_nettype none
module dac_serial_write_port_test import dacswp_pkg::*;;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    wire sclk, sel_n, din;
    logic [CODE_BITS-1:0] code;
    logic [FRAME_BITS-1:0] word, exp_w;
    logic upd, busy;
    int err_count = 0, n_checks = 0, n_upd = 0, cyc = 0, base;
    logic [31:0] seed = 32'h00008e8f;
    always #2.5 clk_sys_i = ~clk_sys_i;
    dacswp_host host (.sclk_o(sclk), .sel_n_o(sel_n), .din_o(din));
    dacswp_port #(.WORD_W(FRAME_BITS)) uut (.clk_sys_i, .rst_i, .sclk_i(sclk), .sel_n_i(sel_n),
        .din_i(din), .analog_output_code_o(code), .frame_word_o(word), .update_o(upd),
        .busy_o(busy));
    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : conclude
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (upd === 1'b1) n_upd <= n_upd + 1;
        if (cyc == 40000) begin
            err_count++;
            conclude();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        return s ^ (s << 5);
    endfunction : xs
    // only a frame of 24 or more falls replaces the word
    function automatic logic [23:0] expect_word(input logic [23:0] old, w, input int n);
        return (n >= FRAME_BITS) ? w : old;
    endfunction : expect_word
    task automatic run(input logic [23:0] w, input int n);
        base = n_upd;
        @(negedge clk_sys_i);
        host.frame(w, n);
        exp_w = expect_word(exp_w, w, n);
        n_checks++;
        if (word !== exp_w || code !== exp_w[15:0]
            || n_upd - base != int'(n >= FRAME_BITS)) begin
            err_count++;
            $display("[FAIL] %0t word %h exp %h n %0d", $time, word, exp_w, n);
        end
        $display("frame of %0d done", n);
    endtask : run
    // between frames nothing shifts and no update stands
    task automatic check_idle(input logic [23:0] w);
        n_checks++;
        if (word !== w || code !== w[15:0] || busy !== 1'b0 || upd !== 1'b0) begin
            err_count++;
            $display("[FAIL] %0t idle word %h busy %b exp %h", $time, word, busy, w);
        end
        $display("idle check done");
    endtask : check_idle
    initial begin
        exp_w = WORD_RST;
        repeat (20) @(negedge clk_sys_i);
        rst_i = 1'b0;
        check_idle(WORD_RST);
        run(24'hffffff, 24);
        run(24'h000000, 23);
        run(24'h000000, 24);
        run(24'h5a3c96, 30);
        run(24'h123456, 1);
        for (int i = 0; i < 30; i++) begin
            seed = xs(seed);
            run(seed[23:0], seed[31] ? 24 : int'(seed[28:24]));
        end
        check_idle(exp_w);
        @(negedge clk_sys_i);
        rst_i = 1'b1;
        repeat (3) @(negedge clk_sys_i);
        rst_i = 1'b0;
        exp_w = WORD_RST;
        check_idle(exp_w);
        run(24'ha5c3e1, 25);
        conclude();
    end
endmodule : dac_serial_write_port_test
`default_nettype wire
